// *** hw/dalu_map.vh ***
// Constants for the DSP fixed-point ALU: widths, codes, limits, reset values
`ifndef DALU_MAP_VH
`define DALU_MAP_VH

// Word layout
`define DALU_DATA_W        32
`define DALU_GUARD_W       8
`define DALU_WORD_W        40

// Operation codes
`define DALU_OP_ADD        4'h0
`define DALU_OP_SUB        4'h1
`define DALU_OP_ADDC       4'h2
`define DALU_OP_SUBC       4'h3
`define DALU_OP_CMP        4'h4
`define DALU_OP_COPY       4'h5
`define DALU_OP_ABS        4'h6
`define DALU_OP_NEG        4'h7
`define DALU_OP_CLR        4'h8

// Register bank indices
`define DALU_REG_X0        3'h0
`define DALU_REG_X1        3'h1
`define DALU_REG_Y0        3'h2
`define DALU_REG_Y1        3'h3
`define DALU_REG_M0        3'h4
`define DALU_REG_M1        3'h5
`define DALU_REG_A0        3'h6
`define DALU_REG_A1        3'h7

// Condition select modes
`define DALU_CS_CARRY      3'h0
`define DALU_CS_NEG        3'h1
`define DALU_CS_ZERO       3'h2
`define DALU_CS_OVF        3'h3
`define DALU_CS_GT         3'h4
`define DALU_CS_GE         3'h5

// Conditional execution forms
`define DALU_COND_NONE     2'h0
`define DALU_COND_TRUE     2'h1
`define DALU_COND_FALSE    2'h2

// Saturation limits
`define DALU_MAX40         40'h7FFFFFFFFF
`define DALU_MIN40         40'h8000000000
`define DALU_MAX32         40'h007FFFFFFF
`define DALU_MIN32         40'hFF80000000

// Reset values
`define DALU_REG_RST       40'h0000000000
`define DALU_FLAG_RST      1'b0
`define DALU_CS_RST        3'h0

`endif

// *** hw/dalu_operand.v ***
// Operand conditioner: sign-extends registers that lack guard bits
`timescale 1ns/1ns
`include "dalu_map.vh"

module dalu_operand (
    input  wire [39:0] regValue,
    input  wire        hasGuardBits,
    output wire [39:0] operand
);

    // Guard bits copied from the data sign bit when absent
    assign operand = hasGuardBits ? regValue :
                     {{`DALU_GUARD_W{regValue[31]}}, regValue[31:0]};

endmodule // dalu_operand

// *** hw/dalu_sat.v ***
// Range checks and saturation of the 41-bit raw sum
`timescale 1ns/1ns
`include "dalu_map.vh"

module dalu_sat (
    input  wire [40:0] rawSum,
    input  wire        dstGuard,
    input  wire        satEnable,
    output wire [39:0] value,
    output wire        dataOverflow,
    output wire        rangeExceeded
);

    wire        fits32;
    wire        fits40;
    wire        trueSign;
    wire [39:0] limit;

    assign fits32   = (rawSum[40:31] == 10'h000) || (rawSum[40:31] == 10'h3FF);
    assign fits40   = (rawSum[40] == rawSum[39]);
    assign trueSign = rawSum[40];

    // Overflow judged on the data part only
    assign dataOverflow = ~((rawSum[39:31] == 9'h000) || (rawSum[39:31] == 9'h1FF));

    // Guard-inclusive range of the destination
    assign rangeExceeded = dstGuard ? ~fits40 : ~fits32;

    assign limit = dstGuard ? (trueSign ? `DALU_MIN40 : `DALU_MAX40) :
                              (trueSign ? `DALU_MIN32 : `DALU_MAX32);

    assign value = (satEnable && rangeExceeded) ? limit : rawSum[39:0];

endmodule // dalu_sat

// *** hw/dalu_top.v ***
// DSP fixed-point ALU: register bank, 40-bit datapath, status flags
//
// Functional notes
// - Operate on 32 data plus 8 guard bits.
// - Sign-extend sources lacking guard bits.
// - Non-guard destinations keep only low 32 bits.
// - Independent register selection; guard bits participate.
// - Execute, write, flag update in final stage.
// - Only unconditional operations update the flags.
// - Add-carry and subtract force carry/borrow decision.
// - Same-line load: ALU sees old value.
// - Add, sub, carry, compare, copy, abs, negate, clear.
// - Restricted source and paired destination register sets.
// - Mode 000: carry/borrow out of data MSB.
// - Mode 001: decision equals 40-bit sign.
// - Mode 010: decision equals zero result.
// - Mode 011: decision equals 32-bit overflow.
// - Mode 100: not((N xor range) or Z).
// - Mode 101: not(N xor range).
// - Negative flag follows result sign.
// - Zero flag set on zero result.
// - Overflow flag: exceeds range without guard bits.
// - Greater flag: signed first above second.
// - Saturate on overflow when enabled.
// - Conditional forms execute on flag true/false.
`timescale 1ns/1ns
`include "dalu_map.vh"

module dalu_top #(
    parameter NUM_REGS = 8
) (
    input  wire        mclk,
    input  wire        reset,
    input  wire        issueValid,
    input  wire [3:0]  opCode,
    input  wire        srcUseY,
    input  wire [1:0]  firstSel,
    input  wire [1:0]  secondSel,
    input  wire [2:0]  destSel,
    input  wire        pairedDestEn,
    input  wire [1:0]  pairedDestSel,
    input  wire [1:0]  condMode,
    input  wire [2:0]  condSelect,
    input  wire        saturateEnable,
    input  wire        loadValid,
    input  wire [2:0]  loadSel,
    input  wire [31:0] loadData,
    input  wire [2:0]  readSel,
    output wire [39:0] readData,
    output wire [39:0] resultData,
    output wire        resultValid,
    output wire        flagsUpdated,
    output wire        decisionFlag,
    output wire        negativeFlag,
    output wire        zeroFlag,
    output wire        overflowFlag,
    output wire        greaterFlag
);

    // Register index of each first-source code
    function [2:0] firstIdx;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    firstIdx = `DALU_REG_X0;
                2'h1:    firstIdx = `DALU_REG_X1;
                2'h2:    firstIdx = `DALU_REG_A0;
                default: firstIdx = `DALU_REG_A1;
            endcase
        end
    endfunction

    // Register index of each second-source code
    function [2:0] secondIdx;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    secondIdx = `DALU_REG_Y0;
                2'h1:    secondIdx = `DALU_REG_Y1;
                2'h2:    secondIdx = `DALU_REG_M0;
                default: secondIdx = `DALU_REG_M1;
            endcase
        end
    endfunction

    // Register index of each paired-destination code
    function [2:0] pairIdx;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    pairIdx = `DALU_REG_X0;
                2'h1:    pairIdx = `DALU_REG_Y0;
                2'h2:    pairIdx = `DALU_REG_A0;
                default: pairIdx = `DALU_REG_A1;
            endcase
        end
    endfunction

    // Only the accumulators carry guard bits
    function hasGuard;
        input [2:0] idx;
        begin
            hasGuard = (idx == `DALU_REG_A0) || (idx == `DALU_REG_A1);
        end
    endfunction

    wire [40*NUM_REGS-1:0] bankFlat;
    wire [2:0]             xIdx;
    wire [2:0]             yIdx;
    wire [2:0]             destIdx;
    wire [39:0]            xRaw;
    wire [39:0]            yRaw;
    wire [39:0]            xOperand;
    wire [39:0]            yOperand;
    wire                   dstGuard;
    wire                   execute;
    wire                   writeEn;
    wire                   flagEn;
    wire [40:0]            rawSum;
    wire [32:0]            lowSum;
    wire                   dataCarry;
    wire [39:0]            satValue;
    wire [39:0]            writeValue;
    wire                   ovfData;
    wire                   rangeTerm;
    wire                   resNeg;
    wire                   resZero;
    wire                   resGreater;

    reg  [39:0]            addA;
    reg  [39:0]            addB;
    reg                    addCin;
    reg                    isSub;
    reg                    decisionNew;

    reg                    decision_q;
    reg                    negative_q;
    reg                    zero_q;
    reg                    overflow_q;
    reg                    greater_q;
    reg  [39:0]            result_q;
    reg                    resultValid_q;
    reg                    flagsUpdated_q;
    reg  [39:0]            readData_q;

    // Source selection from restricted sets
    // source set mapping
    assign xIdx = firstIdx(firstSel);
    assign yIdx = secondIdx(secondSel);

    assign destIdx = pairedDestEn ? pairIdx(pairedDestSel) : destSel;

    assign xRaw = bankFlat[40*xIdx +: 40];
    assign yRaw = bankFlat[40*yIdx +: 40];

    dalu_operand uOperandX (
        .regValue     (xRaw),
        .hasGuardBits (hasGuard(xIdx)),
        .operand      (xOperand)
    );

    dalu_operand uOperandY (
        .regValue     (yRaw),
        .hasGuardBits (hasGuard(yIdx)),
        .operand      (yOperand)
    );

    // Compare has no destination; judged on the full 40-bit range
    assign dstGuard = hasGuard(destIdx) || (opCode == `DALU_OP_CMP);

    assign execute = issueValid &&
                     ((condMode == `DALU_COND_NONE) ||
                      ((condMode == `DALU_COND_TRUE) && decision_q) ||
                      ((condMode == `DALU_COND_FALSE) && !decision_q));

    assign writeEn = execute && (opCode != `DALU_OP_CMP);

    assign flagEn = issueValid && (condMode == `DALU_COND_NONE);

    // Operand steering onto the single adder
    // operation decode
    always @* begin
        addA   = `DALU_REG_RST;
        addB   = `DALU_REG_RST;
        addCin = 1'b0;
        isSub  = 1'b0;
        case (opCode)
            `DALU_OP_ADD: begin
                addA = xOperand;
                addB = yOperand;
            end
            `DALU_OP_SUB, `DALU_OP_CMP: begin
                addA   = xOperand;
                addB   = ~yOperand;
                addCin = 1'b1;
                isSub  = 1'b1;
            end
            `DALU_OP_ADDC: begin
                addA   = xOperand;
                addB   = yOperand;
                addCin = decision_q;
            end
            `DALU_OP_SUBC: begin
                addA   = xOperand;
                addB   = ~yOperand;
                addCin = ~decision_q;
                isSub  = 1'b1;
            end
            `DALU_OP_COPY: begin
                addA = srcUseY ? yOperand : xOperand;
            end
            `DALU_OP_ABS: begin
                if ((srcUseY ? yOperand[39] : xOperand[39])) begin
                    addB   = srcUseY ? ~yOperand : ~xOperand;
                    addCin = 1'b1;
                    isSub  = 1'b1;
                end else begin
                    addA = srcUseY ? yOperand : xOperand;
                end
            end
            `DALU_OP_NEG: begin
                addB   = srcUseY ? ~yOperand : ~xOperand;
                addCin = 1'b1;
                isSub  = 1'b1;
            end
            `DALU_OP_CLR: begin
                addA = `DALU_REG_RST;
            end
            default: begin
                addA = `DALU_REG_RST;
            end
        endcase
    end

    // 40-bit sum with one extra bit
    assign rawSum = {addA[39], addA} + {addB[39], addB} + {40'h0000000000, addCin};

    // carry out of data MSB only
    assign lowSum    = {1'b0, addA[31:0]} + {1'b0, addB[31:0]} + {32'h00000000, addCin};
    assign dataCarry = isSub ? ~lowSum[32] : lowSum[32];

    dalu_sat uSat (
        .rawSum        (rawSum),
        .dstGuard      (dstGuard),
        .satEnable     (saturateEnable),
        .value         (satValue),
        .dataOverflow  (ovfData),
        .rangeExceeded (rangeTerm)
    );

    assign writeValue = hasGuard(destIdx) ? satValue :
                        {{`DALU_GUARD_W{satValue[31]}}, satValue[31:0]};

    assign resNeg = rawSum[39];

    assign resZero = (rawSum[39:0] == `DALU_REG_RST);

    assign resGreater = ~((resNeg ^ rangeTerm) | resZero);

    // Decision flag source
    always @* begin
        if ((opCode == `DALU_OP_ADDC) || (opCode == `DALU_OP_SUB)) begin
            decisionNew = dataCarry;
        end else begin
            case (condSelect)
                `DALU_CS_CARRY: decisionNew = dataCarry;
                `DALU_CS_NEG:   decisionNew = resNeg;
                `DALU_CS_ZERO:  decisionNew = resZero;
                `DALU_CS_OVF:   decisionNew = ovfData;
                `DALU_CS_GT:    decisionNew = ~((resNeg ^ rangeTerm) | resZero);
                `DALU_CS_GE:    decisionNew = ~(resNeg ^ rangeTerm);
                default:        decisionNew = 1'b0;
            endcase
        end
    end

    // Register bank, one generate slot per register
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi = gi + 1) begin : gBank
            reg [39:0] value_q;

            always @(posedge mclk or posedge reset) begin
                if (reset) begin
                    value_q <= `DALU_REG_RST;
                end else if (loadValid && (loadSel == gi)) begin
                    value_q <= {{`DALU_GUARD_W{loadData[31]}}, loadData};
                end else if (writeEn && (destIdx == gi)) begin
                    value_q <= writeValue;
                end
            end

            assign bankFlat[40*gi +: 40] = value_q;
        end
    endgenerate

    // Status flags
    // flag update gate
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            decision_q <= `DALU_FLAG_RST;
            negative_q <= `DALU_FLAG_RST;
            zero_q     <= `DALU_FLAG_RST;
            overflow_q <= `DALU_FLAG_RST;
            greater_q  <= `DALU_FLAG_RST;
        end else if (flagEn) begin
            decision_q <= decisionNew;
            negative_q <= resNeg;
            zero_q     <= resZero;
            overflow_q <= ovfData;
            greater_q  <= resGreater;
        end
    end

    // Result view and event pulses
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            result_q       <= `DALU_REG_RST;
            resultValid_q  <= 1'b0;
            flagsUpdated_q <= 1'b0;
        end else begin
            resultValid_q  <= writeEn;
            flagsUpdated_q <= flagEn;
            if (writeEn) begin
                result_q <= writeValue;
            end
        end
    end

    // Registered bank readback, one cycle behind the select
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            readData_q <= `DALU_REG_RST;
        end else begin
            readData_q <= bankFlat[40*readSel +: 40];
        end
    end

    assign readData     = readData_q;
    assign resultData   = result_q;
    assign resultValid  = resultValid_q;
    assign flagsUpdated = flagsUpdated_q;
    assign decisionFlag = decision_q;
    assign negativeFlag = negative_q;
    assign zeroFlag     = zero_q;
    assign overflowFlag = overflow_q;
    assign greaterFlag  = greater_q;

endmodule // dalu_top

// *** testbench/dalu_dec_model.sv ***
// Decoder model: splits an issue word into the ALU operand fields
`timescale 1ns/1ns

module dalu_dec_model (
    input  wire [20:0] word,
    output wire [3:0]  opCode,
    output wire        srcUseY,
    output wire [1:0]  firstSel,
    output wire [1:0]  secondSel,
    output wire [2:0]  destSel,
    output wire        pairedDestEn,
    output wire [1:0]  pairedDestSel,
    output wire [1:0]  condMode,
    output wire [2:0]  condSelect,
    output wire        saturateEnable
);
    // Field order is the bench's own issue-word layout
    assign {saturateEnable, condSelect, condMode, pairedDestEn, pairedDestSel,
            destSel, secondSel, firstSel, srcUseY, opCode} = word;
endmodule // dalu_dec_model

// *** testbench/dalu_sva.sv ***
// Checker for the DSP fixed-point ALU port behaviour
`timescale 1ns/1ns
`include "dalu_map.vh"

module dalu_sva (
    input wire        mclk,
    input wire        reset,
    input wire        issueValid,
    input wire [3:0]  opCode,
    input wire [2:0]  destSel,
    input wire        pairedDestEn,
    input wire [1:0]  condMode,
    input wire [2:0]  condSelect,
    input wire [39:0] resultData,
    input wire        resultValid,
    input wire        flagsUpdated,
    input wire        decisionFlag,
    input wire        negativeFlag,
    input wire        zeroFlag,
    input wire        overflowFlag,
    input wire        greaterFlag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    wire uncond;
    wire noForce;
    assign uncond  = issueValid && condMode == `DALU_COND_NONE;
    assign noForce = opCode != `DALU_OP_ADDC && opCode != `DALU_OP_SUB;

    AST_WRITE: assert property (uncond && opCode != `DALU_OP_CMP |=> resultValid)
        else $error("destination write pulse missing");
    AST_CMP_NOWR: assert property (issueValid && opCode == `DALU_OP_CMP |=> !resultValid)
        else $error("compare wrote a destination");
    AST_UPD: assert property (uncond |=> flagsUpdated)
        else $error("unconditional op left flags alone");
    AST_COND_KEEP: assert property (issueValid && condMode != `DALU_COND_NONE |=> !flagsUpdated)
        else $error("conditional op updated flags");
    AST_COND_SKIP: assert property (issueValid && ((condMode == `DALU_COND_TRUE && !decisionFlag)
        || (condMode == `DALU_COND_FALSE && decisionFlag)) |=> !resultValid && !flagsUpdated)
        else $error("skipped op took effect");
    AST_HOLD: assert property (!flagsUpdated |-> $stable({decisionFlag, negativeFlag,
        zeroFlag, overflowFlag, greaterFlag}))
        else $error("flags moved without update");
    AST_DC_NEG: assert property (uncond && noForce && condSelect == `DALU_CS_NEG
        |=> decisionFlag == negativeFlag)
        else $error("decision differs from negative");
    AST_DC_ZERO: assert property (uncond && noForce && condSelect == `DALU_CS_ZERO
        |=> decisionFlag == zeroFlag)
        else $error("decision differs from zero");
    AST_DC_OVF: assert property (uncond && noForce && condSelect == `DALU_CS_OVF
        |=> decisionFlag == overflowFlag)
        else $error("decision differs from overflow");
    AST_DC_GT: assert property (uncond && noForce && condSelect == `DALU_CS_GT
        |=> decisionFlag == greaterFlag)
        else $error("decision differs from greater");
    AST_CLR: assert property (uncond && opCode == `DALU_OP_CLR
        |=> resultData == 40'h0000000000 && zeroFlag && !negativeFlag)
        else $error("clear result or zero flag wrong");
    AST_GUARD: assert property (uncond && opCode != `DALU_OP_CMP && !pairedDestEn
        && destSel < `DALU_REG_A0 |=> resultData[39:32] == {8{resultData[31]}})
        else $error("narrow destination not sign-extended");
endmodule // dalu_sva

bind dalu_top dalu_sva u_sva (
    .mclk         (mclk),
    .reset        (reset),
    .issueValid   (issueValid),
    .opCode       (opCode),
    .destSel      (destSel),
    .pairedDestEn (pairedDestEn),
    .condMode     (condMode),
    .condSelect   (condSelect),
    .resultData   (resultData),
    .resultValid  (resultValid),
    .flagsUpdated (flagsUpdated),
    .decisionFlag (decisionFlag),
    .negativeFlag (negativeFlag),
    .zeroFlag     (zeroFlag),
    .overflowFlag (overflowFlag),
    .greaterFlag  (greaterFlag)
);

// *** testbench/test_dsp_alu_fixed_point_flags.sv ***
// Self-checking bench for the DSP fixed-point ALU
`timescale 1ns/1ns

module test_dsp_alu_fixed_point_flags;
    localparam [20:0] USEY = 21'h000010;
    localparam [20:0] PDA1 = 21'h007000;
    localparam [20:0] CMT  = 21'h008000;
    localparam [20:0] CMF  = 21'h010000;
    localparam [20:0] SAT  = 21'h100000;
    reg         mclk;
    reg         reset;
    reg         issueValid;
    reg  [20:0] word;
    reg         loadValid;
    reg  [2:0]  loadSel;
    reg  [31:0] loadData;
    reg  [2:0]  readSel;
    integer     mismatches;
    integer     cmpCount;
    wire [3:0]  opCode;
    wire        srcUseY;
    wire [1:0]  firstSel;
    wire [1:0]  secondSel;
    wire [2:0]  destSel;
    wire        pairedDestEn;
    wire [1:0]  pairedDestSel;
    wire [1:0]  condMode;
    wire [2:0]  condSelect;
    wire        saturateEnable;
    wire [39:0] readData;
    wire [39:0] resultData;
    wire        resultValid;
    wire        flagsUpdated;
    wire [4:0]  flags;

    dalu_dec_model u_dec (.word(word), .opCode(opCode), .srcUseY(srcUseY),
        .firstSel(firstSel), .secondSel(secondSel), .destSel(destSel),
        .pairedDestEn(pairedDestEn), .pairedDestSel(pairedDestSel),
        .condMode(condMode), .condSelect(condSelect), .saturateEnable(saturateEnable));

    dalu_top #(.NUM_REGS(8)) u_dut (.mclk(mclk), .reset(reset), .issueValid(issueValid),
        .opCode(opCode), .srcUseY(srcUseY), .firstSel(firstSel), .secondSel(secondSel),
        .destSel(destSel), .pairedDestEn(pairedDestEn), .pairedDestSel(pairedDestSel),
        .condMode(condMode), .condSelect(condSelect), .saturateEnable(saturateEnable),
        .loadValid(loadValid), .loadSel(loadSel), .loadData(loadData), .readSel(readSel),
        .readData(readData), .resultData(resultData), .resultValid(resultValid),
        .flagsUpdated(flagsUpdated), .decisionFlag(flags[4]), .negativeFlag(flags[3]),
        .zeroFlag(flags[2]), .overflowFlag(flags[1]), .greaterFlag(flags[0]));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    function [20:0] mk(input [3:0] o, input [1:0] f, input [1:0] s, input [2:0] d,
                       input [2:0] c);
        mk = {1'b0, c, 2'h0, 3'h0, d, s, f, 1'b0, o};
    endfunction

    task wrapUp;
        begin
            if (mismatches == 0 && cmpCount > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask

    task chk(input [46:0] got, input [46:0] exp);
        begin
            cmpCount = cmpCount + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // Issue one line, then look at the outputs just after its take edge
    task op(input iv, input [20:0] w, input lv, input [2:0] ls, input [31:0] ld,
            input doChk, input [39:0] eRes, input [4:0] eFl, input [1:0] eV);
        begin
            @(posedge mclk);
            issueValid <= iv;
            word       <= w;
            loadValid  <= lv;
            loadSel    <= ls;
            loadData   <= ld;
            @(posedge mclk);
            issueValid <= 1'b0;
            loadValid  <= 1'b0;
            #1;
            if (doChk) begin
                chk({resultData, flags, resultValid, flagsUpdated}, {eRes, eFl, eV});
            end
        end
    endtask

    task ld(input [2:0] s, input [31:0] d);
        op(1'b0, 21'h0, 1'b1, s, d, 1'b0, 40'h0, 5'h00, 2'h0);
    endtask

    task alu(input [20:0] w, input [39:0] e, input [4:0] f, input [1:0] v);
        op(1'b1, w, 1'b0, 3'h0, 32'h0, 1'b1, e, f, v);
    endtask

    task rd(input [2:0] s, input [39:0] e);
        begin
            @(posedge mclk);
            readSel <= s;
            @(posedge mclk);
            #1;
            chk({7'h00, readData}, {7'h00, e});
        end
    endtask

    initial begin
        reset      = 1'b1;
        issueValid = 1'b0;
        word       = 21'h0;
        loadValid  = 1'b0;
        loadSel    = 3'h0;
        loadData   = 32'h0;
        readSel    = 3'h0;
        mismatches = 0;
        cmpCount   = 0;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        op(1'b0, 21'h0, 1'b0, 3'h0, 32'h0, 1'b1, 40'h0, 5'h00, 2'h0); // reset state
        ld(3'h0, 32'h7FFFFFFF); // operand setup
        ld(3'h2, 32'h00000001); // operand setup
        ld(3'h3, 32'hFFFFFFFF); // operand setup
        ld(3'h1, 32'hFFFFFFFF); // operand setup
        rd(3'h1, 40'hFFFFFFFFFF); // sign fill
        alu(mk(4'h0, 2'h0, 2'h0, 3'h6, 3'h0), 40'h0080000000, 5'h03, 2'h3); // add
        alu(mk(4'h0, 2'h0, 2'h0, 3'h5, 3'h3), 40'hFF80000000, 5'h12, 2'h3); // wrap
        alu(mk(4'h0, 2'h0, 2'h0, 3'h5, 3'h3) | SAT, 40'h007FFFFFFF, 5'h12, 2'h3); // clip
        alu(mk(4'h1, 2'h0, 2'h1, 3'h7, 3'h2), 40'h0080000000, 5'h13, 2'h3); // borrow
        alu(mk(4'h4, 2'h2, 2'h0, 3'h0, 3'h5), 40'h0080000000, 5'h11, 2'h1); // compare
        alu(mk(4'h5, 2'h0, 2'h0, 3'h4, 3'h0) | CMT, 40'h007FFFFFFF, 5'h11, 2'h2); // taken
        alu(mk(4'h7, 2'h0, 2'h0, 3'h6, 3'h0) | CMF, 40'h007FFFFFFF, 5'h11, 2'h0); // skip
        alu(mk(4'h8, 2'h0, 2'h0, 3'h7, 3'h2), 40'h0000000000, 5'h14, 2'h3); // clear
        alu(mk(4'h2, 2'h1, 2'h0, 3'h6, 3'h2), 40'h0000000001, 5'h11, 2'h3); // carry
        alu(mk(4'h3, 2'h0, 2'h0, 3'h7, 3'h2), 40'h007FFFFFFD, 5'h01, 2'h3); // borrow in
        alu(mk(4'h7, 2'h0, 2'h0, 3'h6, 3'h1) | USEY, 40'hFFFFFFFFFF, 5'h18, 2'h3); // neg
        alu(mk(4'h6, 2'h0, 2'h1, 3'h7, 3'h1) | USEY, 40'h0000000001, 5'h01, 2'h3); // abs
        op(1'b1, mk(4'h0, 2'h0, 2'h0, 3'h6, 3'h1), 1'b1, 3'h2, 32'h00000005, // old value
           1'b1, 40'h0080000000, 5'h03, 2'h3);
        rd(3'h2, 40'h0000000005); // load lands
        alu(mk(4'h0, 2'h0, 2'h0, 3'h0, 3'h4) | PDA1, 40'h0080000004, 5'h13, 2'h3); // gt
        rd(3'h7, 40'h0080000004); // paired target
        rd(3'h0, 40'h007FFFFFFF); // untouched
        alu(mk(4'h0, 2'h1, 2'h0, 3'h6, 3'h0), 40'h0000000004, 5'h11, 2'h3); // carry
        alu(mk(4'h6, 2'h0, 2'h0, 3'h5, 3'h0), 40'h007FFFFFFF, 5'h01, 2'h3); // abs pos
        alu(mk(4'h8, 2'h0, 2'h0, 3'h6, 3'h0) | CMT | CMF, 40'h007FFFFFFF, 5'h01, 2'h0);
        rd(3'h6, 40'h0000000004); // no write
        wrapUp;
    end
endmodule // test_dsp_alu_fixed_point_flags
